// ---- e1fac_frame_align_control.sv ----
// E1 framer control block with its Avalon-MM register slave.
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ps

// How it works
// RQ1: Resync starts only on manual bit rising.
// RQ2: Auto resync runs unless auto_realign_off set.
// RQ3: Three bad FAS, optionally bad bit-2, resync.
// RQ4: Receive HDB3 decoding only when enabled.
// RQ5: Signal loss after 255 or 2048 zeros.
// RQ6: Software writes zero to unused control bits.
// RQ7: Frame lock needs FAS, gap, FAS.
// RQ8: CRC4 lock on two MF words in 8 ms.
// RQ9: CRC4 resync when 915 of 1000 bad.
// RQ10: CAS lock needs MF word, nonzero TS16.
// RQ11: CAS resync after two bad MF words.
// RQ12: Latch CAS, FAS, CRC resync events.
// RQ13: Transmit HDB3 encoding only when enabled.
// RQ14: International bits from serial or registers.
// RQ15: Slot 0 overhead internal or pass-through.
// RQ16: Search-active flags high while searching.
// RQ17: CRC search counter counts timeouts, clears.
// RQ18: Expose counter bits 0, 2 to 5.
// RQ19: Software abandons CRC4 search after 400 ms.
// RQ20: Frame loss at power-up and on resync.
// RQ21: Signal loss clears on 32 ones/255 bits.
// RQ22: Event flags stay until register is read.
module e1fac_frame_align_control
    import e1fac_pkg::*;
#(
    parameter int CRC_SEARCH_CYC = E1FAC_CRC_SEARCH_CYC
)
(
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic rx_line_pos_i,
    input wire logic rx_line_neg_i,
    input wire logic rx_line_clk_i,
    output logic rx_data_o,
    output logic rx_data_vld_o,
    output logic rx_signal_loss_o,
    output logic rx_frame_loss_o,
    input wire logic frm_stb_i,
    input wire logic frm_fas_ok_i,
    input wire logic frm_bit2_ok_i,
    input wire logic crc_mf_stb_i,
    input wire logic crc_mf_ok_i,
    input wire logic crc_word_stb_i,
    input wire logic crc_word_err_i,
    input wire logic cas_mf_stb_i,
    input wire logic cas_mf_ok_i,
    input wire logic cas_ts16_nonzero_i,
    input wire logic tx_serial_in_i,
    input wire logic tx_ovh_bit_i,
    input wire logic tx_ts0_pos_i,
    input wire logic tx_si_pos_i,
    output logic tx_bit_stb_o,
    output logic tx_line_pos_o,
    output logic tx_line_neg_o
);

    // Timeout count at timer width.
    localparam logic [18:0] CRC_TMR_LAST = 19'(CRC_SEARCH_CYC - 1);

    // Saturating two-bit increment.
    function automatic logic [1:0] e1fac_bump2(input logic [1:0] cnt);
        e1fac_bump2 = (cnt == 2'd3) ? cnt : cnt + 2'd1;
    endfunction : e1fac_bump2

    e1fac_state_s st_ff;
    e1fac_state_s nxt_st;

    logic req;
    logic hit;
    logic [5:0] idx;
    logic [7:0] rd_val;
    logic [7:0] sync_info;
    logic manual_rise;
    logic auto_on;
    logic realign;
    logic fas_crit;
    logic crc_crit;
    logic cas_crit;
    logic fas_locked;
    logic crc_on;
    logic cas_on;
    logic rx_edge;
    logic rx_pulse;
    logic rx_viol;
    logic [11:0] los_limit;
    logic tx_bit;
    logic enc_sub;
    logic [17:0] acc_sum;
    logic out_pol;

    // Next-state logic for the whole block.
    always_comb
    begin
        nxt_st = st_ff;
        req = avs_read_i | avs_write_i;
        idx = avs_address_i[7:2];
        hit = (avs_address_i[1:0] == 2'b00);
        fas_locked = (st_ff.fas_st == FAS_LOCKED);
        crc_on = st_ff.mode[E1FAC_MODE_CRC4_EN] & fas_locked;
        cas_on = st_ff.mode[E1FAC_MODE_CAS_EN] & fas_locked;
        auto_on = ~st_ff.rcr[E1FAC_RCR_AUTO_REALIGN_OFF];
        fas_crit = 1'b0;
        crc_crit = 1'b0;
        cas_crit = 1'b0;

        // Search view; counter bit 1 is hidden so five bits reach past 400 ms.
        sync_info = {st_ff.crc_cnt[5:2], st_ff.crc_cnt[0],                   // [RQ18]
                     ~fas_locked, cas_on & ~st_ff.cas_sync, crc_on & ~st_ff.crc_sync}; // [RQ16]

        // Register read mux; unmapped addresses read as zero.
        rd_val = 8'h00;
        if (hit)
        begin
            case (idx)
                E1FAC_IDX_REALIGN_EVENT_INFO: rd_val = {5'h00, st_ff.evt};
                E1FAC_IDX_SYNC_SEARCH_INFO: rd_val = sync_info;
                E1FAC_IDX_E1_RECEIVE_CONTROL: rd_val = st_ff.rcr;
                E1FAC_IDX_E1_TRANSMIT_CONTROL: rd_val = st_ff.tcr;
                E1FAC_IDX_FRAMER_MODE: rd_val = st_ff.mode;
                default: rd_val = 8'h00;
            endcase
        end

        // One wait cycle, then a one-cycle answer.
        nxt_st.busy = ~(req & st_ff.busy);
        if (req & st_ff.busy)
        begin
            nxt_st.rdata = rd_val;
            nxt_st.rdata_idx = {hit, 1'b0, idx};
        end
        if (avs_write_i & ~st_ff.busy & hit & avs_byteenable_i[0])
        begin
            // Unused bits are not stored. [RQ6]
            case (idx)
                E1FAC_IDX_E1_RECEIVE_CONTROL: nxt_st.rcr = avs_writedata_i[7:0] & E1FAC_RCR_MASK;
                E1FAC_IDX_E1_TRANSMIT_CONTROL: nxt_st.tcr = avs_writedata_i[7:0] & E1FAC_TCR_MASK;
                E1FAC_IDX_FRAMER_MODE: nxt_st.mode = avs_writedata_i[7:0] & E1FAC_MODE_MASK;
                default: nxt_st.rcr = st_ff.rcr;
            endcase
        end

        // Only a fresh rising edge starts a resync.
        manual_rise = st_ff.rcr[E1FAC_RCR_MANUAL_REALIGN] & ~st_ff.manual_prev; // [RQ1]
        nxt_st.manual_prev = st_ff.rcr[E1FAC_RCR_MANUAL_REALIGN];

        // Line pins pass two flip-flops; the clock edge is found past the second.
        nxt_st.rx_s1 = {rx_line_clk_i, rx_line_neg_i, rx_line_pos_i};
        nxt_st.rx_s2 = st_ff.rx_s1;
        nxt_st.rxc_s3 = st_ff.rx_s2[2];
        rx_edge = st_ff.rx_s2[2] & ~st_ff.rxc_s3;
        rx_pulse = st_ff.rx_s2[0] | st_ff.rx_s2[1];
        rx_viol = rx_pulse & (st_ff.rx_s2[0] == st_ff.dec_last_pos);
        nxt_st.rx_vld = rx_edge;

        // Four-bit delay lets a violation erase its B pulse.
        if (rx_edge)
        begin
            nxt_st.rx_data = st_ff.dec_pipe[3];
            if (rx_pulse)
            begin
                nxt_st.dec_last_pos = st_ff.rx_s2[0];
            end
            if (st_ff.rcr[E1FAC_RCR_RX_ZERO_SUB_CODE_EN] & rx_viol)
            begin
                nxt_st.dec_pipe = {1'b0, st_ff.dec_pipe[1:0], 1'b0}; // [RQ4]
            end
            else
            begin
                nxt_st.dec_pipe = {st_ff.dec_pipe[2:0], rx_pulse};
            end
        end

        // Loss of signal counts raw line zeros, decoding or not.
        los_limit = st_ff.rcr[E1FAC_RCR_RX_SIG_LOSS_LONG_WINDOW] ? E1FAC_LOS_LONG_ZEROS : E1FAC_LOS_SHORT_ZEROS;
        if (rx_edge)
        begin
            if (rx_pulse)
            begin
                nxt_st.zero_cnt = 12'd0;
            end
            else if (st_ff.zero_cnt != E1FAC_LOS_LONG_ZEROS)
            begin
                nxt_st.zero_cnt = st_ff.zero_cnt + 12'd1;
            end
            if (~st_ff.los)
            begin
                if (~rx_pulse & (st_ff.zero_cnt + 12'd1 >= los_limit))
                begin
                    nxt_st.los = 1'b1; // [RQ5]
                    nxt_st.win_cnt = 8'd0;
                    nxt_st.ones_cnt = 6'd0;
                end
            end
            else if (rx_pulse & (st_ff.ones_cnt + 6'd1 >= E1FAC_LOS_CLR_ONES))
            begin
                nxt_st.los = 1'b0; // [RQ21]
            end
            else if (st_ff.win_cnt + 8'd1 >= E1FAC_LOS_CLR_WINDOW)
            begin
                nxt_st.win_cnt = 8'd0;
                nxt_st.ones_cnt = 6'd0;
            end
            else
            begin
                nxt_st.win_cnt = st_ff.win_cnt + 8'd1;
                nxt_st.ones_cnt = st_ff.ones_cnt + {5'h00, rx_pulse};
            end
        end

        // Frame alignment search and in-sync error watch.
        if (frm_stb_i)
        begin
            case (st_ff.fas_st)
                FAS_HUNT: nxt_st.fas_st = frm_fas_ok_i ? FAS_GOT_N : FAS_HUNT;
                FAS_GOT_N: nxt_st.fas_st = frm_fas_ok_i ? FAS_GOT_N : FAS_GOT_GAP;
                FAS_GOT_GAP:
                begin
                    nxt_st.fas_st = frm_fas_ok_i ? FAS_LOCKED : FAS_HUNT; // [RQ7]
                    nxt_st.fas_frame = 1'b0;
                    nxt_st.fas_err = 2'd0;
                    nxt_st.bit2_err = 2'd0;
                end
                FAS_LOCKED:
                begin
                    nxt_st.fas_frame = ~st_ff.fas_frame;
                    if (st_ff.fas_frame)
                    begin
                        nxt_st.fas_err = frm_fas_ok_i ? 2'd0 : e1fac_bump2(st_ff.fas_err);
                        fas_crit = ~frm_fas_ok_i & (e1fac_bump2(st_ff.fas_err) == E1FAC_FAS_ERR_LIMIT); // [RQ3]
                    end
                    else
                    begin
                        nxt_st.bit2_err = frm_bit2_ok_i ? 2'd0 : e1fac_bump2(st_ff.bit2_err);
                        fas_crit = st_ff.rcr[E1FAC_RCR_REALIGN_CRITERION_SEL] & ~frm_bit2_ok_i
                                   & (e1fac_bump2(st_ff.bit2_err) == E1FAC_FAS_ERR_LIMIT); // [RQ3]
                    end
                end
                default: nxt_st.fas_st = FAS_HUNT;
            endcase
        end

        // CRC4 search with timeout count, then block error watch.
        if (~crc_on)
        begin
            nxt_st.crc_sync = 1'b0;
            nxt_st.crc_cnt = 6'd0; // [RQ17]
            nxt_st.crc_tmr = 19'd0;
            nxt_st.crc_found = 2'd0;
        end
        else if (~st_ff.crc_sync)
        begin
            // Wraps after 64 timeouts; the 400 ms limit is software's. [RQ19]
            if (st_ff.crc_tmr >= CRC_TMR_LAST)
            begin
                nxt_st.crc_tmr = 19'd0;
                nxt_st.crc_found = 2'd0;
                nxt_st.crc_cnt = st_ff.crc_cnt + 6'd1; // [RQ17]
            end
            else
            begin
                nxt_st.crc_tmr = st_ff.crc_tmr + 19'd1;
                if (crc_mf_stb_i & crc_mf_ok_i)
                begin
                    nxt_st.crc_found = st_ff.crc_found + 2'd1;
                    if (st_ff.crc_found + 2'd1 == E1FAC_CRC_MF_NEEDED)
                    begin
                        nxt_st.crc_sync = 1'b1; // [RQ8]
                        nxt_st.crc_cnt = 6'd0; // [RQ17]
                        nxt_st.crc_blk = 10'd0;
                        nxt_st.crc_bad = 10'd0;
                    end
                end
            end
        end
        else if (crc_word_stb_i)
        begin
            if (st_ff.crc_blk + 10'd1 == E1FAC_CRC_BLOCK_WORDS)
            begin
                crc_crit = (st_ff.crc_bad + {9'h000, crc_word_err_i}) >= E1FAC_CRC_BAD_WORDS; // [RQ9]
                nxt_st.crc_blk = 10'd0;
                nxt_st.crc_bad = 10'd0;
            end
            else
            begin
                nxt_st.crc_blk = st_ff.crc_blk + 10'd1;
                nxt_st.crc_bad = st_ff.crc_bad + {9'h000, crc_word_err_i};
            end
        end

        // CAS search and error watch.
        if (~cas_on)
        begin
            nxt_st.cas_sync = 1'b0;
            nxt_st.cas_err = 1'b0;
        end
        else if (cas_mf_stb_i)
        begin
            if (~st_ff.cas_sync)
            begin
                nxt_st.cas_sync = cas_mf_ok_i & cas_ts16_nonzero_i; // [RQ10]
                nxt_st.cas_err = 1'b0;
            end
            else
            begin
                nxt_st.cas_err = ~cas_mf_ok_i;
                cas_crit = ~cas_mf_ok_i & st_ff.cas_err; // [RQ11]
            end
        end
        if (cas_crit & auto_on)
        begin
            nxt_st.cas_sync = 1'b0; // [RQ2]
        end

        // Frame or CRC4 resync restarts from the frame search.
        realign = manual_rise | (auto_on & (fas_crit | crc_crit)); // [RQ1] [RQ2]
        if (realign)
        begin
            nxt_st.fas_st = FAS_HUNT; // [RQ20]
            nxt_st.crc_sync = 1'b0;
            nxt_st.cas_sync = 1'b0;
        end
        nxt_st.lof = (nxt_st.fas_st != FAS_LOCKED); // [RQ20]

        // Events latch; a read clears returned bits, a new set wins.
        if (~avs_write_i & avs_read_i & ~st_ff.busy
            && st_ff.rdata_idx == {2'b10, E1FAC_IDX_REALIGN_EVENT_INFO})
        begin
            nxt_st.evt = st_ff.evt & ~st_ff.rdata[2:0]; // [RQ22]
        end
        nxt_st.evt = nxt_st.evt | {crc_crit, fas_crit, cas_crit}; // [RQ12]

        // Bit-rate enable from a fractional divider.
        acc_sum = {1'b0, st_ff.tx_acc} + {1'b0, E1FAC_E1_BIT_KHZ};
        nxt_st.tx_stb = (acc_sum >= {1'b0, E1FAC_SYS_CLK_KHZ});
        nxt_st.tx_acc = nxt_st.tx_stb ? 17'(acc_sum - {1'b0, E1FAC_SYS_CLK_KHZ}) : acc_sum[16:0];

        // Transmit bit source: Si, other slot 0 overhead, or payload.
        if (tx_si_pos_i)
        begin
            tx_bit = st_ff.tcr[E1FAC_TCR_TX_INTL_BIT_SRC] ? tx_ovh_bit_i : tx_serial_in_i; // [RQ14]
        end
        else if (tx_ts0_pos_i)
        begin
            tx_bit = st_ff.tcr[E1FAC_TCR_TX_SLOT0_PASSTHRU] ? tx_serial_in_i : tx_ovh_bit_i; // [RQ15]
        end
        else
        begin
            tx_bit = tx_serial_in_i;
        end

        // Four bits in flight so a B pulse can precede the run.
        enc_sub = st_ff.tcr[E1FAC_TCR_TX_ZERO_SUB_CODE_EN] & ~tx_bit & (st_ff.enc_p[2:0] == 3'b000); // [RQ13]
        out_pol = st_ff.enc_v[3] ? st_ff.enc_last_pos : ~st_ff.enc_last_pos;
        if (st_ff.tx_stb)
        begin
            nxt_st.tx_pos = st_ff.enc_p[3] & out_pol;
            nxt_st.tx_neg = st_ff.enc_p[3] & ~out_pol;
            if (st_ff.enc_p[3])
            begin
                nxt_st.enc_last_pos = out_pol;
            end
            if (enc_sub)
            begin
                nxt_st.enc_p = {~st_ff.enc_par, 2'b00, 1'b1}; // [RQ13]
                nxt_st.enc_v = {1'b0, st_ff.enc_v[1:0], 1'b1};
                nxt_st.enc_par = 1'b0;
            end
            else
            begin
                nxt_st.enc_p = {st_ff.enc_p[2:0], tx_bit};
                nxt_st.enc_v = {st_ff.enc_v[2:0], 1'b0};
                nxt_st.enc_par = st_ff.enc_par ^ tx_bit;
            end
        end
    end

    // State register; starts unsynchronised and idle.
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            st_ff <= '0;
            st_ff.rcr <= E1FAC_RCR_RESET;
            st_ff.tcr <= E1FAC_TCR_RESET;
            st_ff.mode <= E1FAC_MODE_RESET;
            st_ff.busy <= 1'b1;
            st_ff.fas_st <= FAS_HUNT; // [RQ20]
            st_ff.lof <= 1'b1;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // Registered outputs.
    assign avs_readdata_o = {24'h000000, st_ff.rdata};
    assign avs_waitrequest_o = st_ff.busy;
    assign rx_data_o = st_ff.rx_data;
    assign rx_data_vld_o = st_ff.rx_vld;
    assign rx_signal_loss_o = st_ff.los;
    assign rx_frame_loss_o = st_ff.lof; // [RQ20]
    assign tx_bit_stb_o = st_ff.tx_stb;
    assign tx_line_pos_o = st_ff.tx_pos;
    assign tx_line_neg_o = st_ff.tx_neg;

endmodule : e1fac_frame_align_control

// ---- e1fac_pkg.sv ----
// Register map, constants and state types of the E1 framer control block.
package e1fac_pkg;

    // Register indices; byte address is four times the index.
    localparam logic [5:0] E1FAC_IDX_REALIGN_EVENT_INFO = 6'h12;
    localparam logic [5:0] E1FAC_IDX_SYNC_SEARCH_INFO = 6'h1C;
    localparam logic [5:0] E1FAC_IDX_E1_RECEIVE_CONTROL = 6'h1D;
    localparam logic [5:0] E1FAC_IDX_E1_TRANSMIT_CONTROL = 6'h1E;
    localparam logic [5:0] E1FAC_IDX_FRAMER_MODE = 6'h1F;

    // Reset values.
    localparam logic [7:0] E1FAC_RCR_RESET = 8'h00;
    localparam logic [7:0] E1FAC_TCR_RESET = 8'h00;
    localparam logic [7:0] E1FAC_MODE_RESET = 8'h00;

    // Bits that can be stored.
    localparam logic [7:0] E1FAC_RCR_MASK = 8'h67;
    localparam logic [7:0] E1FAC_TCR_MASK = 8'h92;
    localparam logic [7:0] E1FAC_MODE_MASK = 8'h03;

    // Field positions in e1_receive_control.
    localparam int E1FAC_RCR_MANUAL_REALIGN = 0;
    localparam int E1FAC_RCR_AUTO_REALIGN_OFF = 1;
    localparam int E1FAC_RCR_REALIGN_CRITERION_SEL = 2;
    localparam int E1FAC_RCR_RX_ZERO_SUB_CODE_EN = 5;
    localparam int E1FAC_RCR_RX_SIG_LOSS_LONG_WINDOW = 6;

    // Field positions in e1_transmit_control.
    localparam int E1FAC_TCR_TX_ZERO_SUB_CODE_EN = 1;
    localparam int E1FAC_TCR_TX_INTL_BIT_SRC = 4;
    localparam int E1FAC_TCR_TX_SLOT0_PASSTHRU = 7;

    // Field positions in framer_mode.
    localparam int E1FAC_MODE_CRC4_EN = 0;
    localparam int E1FAC_MODE_CAS_EN = 1;

    // Clock and line rates, in kHz.
    localparam logic [16:0] E1FAC_SYS_CLK_KHZ = 17'd50000;
    localparam logic [16:0] E1FAC_E1_BIT_KHZ = 17'd2048;

    // CRC4 search interval.
    localparam int E1FAC_CRC_SEARCH_MS = 8;
    localparam int E1FAC_CRC_SEARCH_CYC = E1FAC_CRC_SEARCH_MS * int'(E1FAC_SYS_CLK_KHZ);

    // Line alarm and resync counts.
    localparam logic [11:0] E1FAC_LOS_SHORT_ZEROS = 12'd255;
    localparam logic [11:0] E1FAC_LOS_LONG_ZEROS = 12'd2048;
    localparam logic [7:0] E1FAC_LOS_CLR_WINDOW = 8'd255;
    localparam logic [5:0] E1FAC_LOS_CLR_ONES = 6'd32;
    localparam logic [1:0] E1FAC_FAS_ERR_LIMIT = 2'd3;
    localparam logic [1:0] E1FAC_CRC_MF_NEEDED = 2'd2;
    localparam logic [9:0] E1FAC_CRC_BLOCK_WORDS = 10'd1000;
    localparam logic [9:0] E1FAC_CRC_BAD_WORDS = 10'd915;

    // Frame alignment states, Gray coded.
    typedef enum logic [1:0]
    {
        FAS_HUNT = 2'b00,
        FAS_GOT_N = 2'b01,
        FAS_GOT_GAP = 2'b11,
        FAS_LOCKED = 2'b10
    } e1fac_fas_e;

    // Whole state of the block.
    typedef struct packed {
        logic [7:0] rcr;
        logic [7:0] tcr;
        logic [7:0] mode;
        logic [2:0] evt;
        logic busy;
        logic [7:0] rdata;
        logic [7:0] rdata_idx;
        logic manual_prev;
        logic [2:0] rx_s1;
        logic [2:0] rx_s2;
        logic rxc_s3;
        logic [3:0] dec_pipe;
        logic dec_last_pos;
        logic rx_vld;
        logic rx_data;
        logic los;
        logic [11:0] zero_cnt;
        logic [7:0] win_cnt;
        logic [5:0] ones_cnt;
        e1fac_fas_e fas_st;
        logic lof;
        logic fas_frame;
        logic [1:0] fas_err;
        logic [1:0] bit2_err;
        logic crc_sync;
        logic [1:0] crc_found;
        logic [18:0] crc_tmr;
        logic [5:0] crc_cnt;
        logic [9:0] crc_blk;
        logic [9:0] crc_bad;
        logic cas_sync;
        logic cas_err;
        logic [16:0] tx_acc;
        logic tx_stb;
        logic [3:0] enc_p;
        logic [3:0] enc_v;
        logic enc_par;
        logic enc_last_pos;
        logic tx_pos;
        logic tx_neg;
    } e1fac_state_s;

endpackage : e1fac_pkg

// ---- e1fac_line_model.sv ----
// Behavioural E1 receive line sending AMI marks or zeros.
`timescale 1ns/1ps
module e1fac_line_model
    import e1fac_pkg::*;
(
    input wire logic ones_i,
    output logic pos_o,
    output logic neg_o,
    output logic clk_o
);
    logic mark_ff = 1'b0;
    // A recovered line clock runs free.
    initial
    begin
        clk_o = 1'b0;
        pos_o = 1'b0;
        neg_o = 1'b0;
    end
    always #244 clk_o = ~clk_o;
    // Data moves on the falling edge so it is sampled mid-bit.
    always @(negedge clk_o)
    begin
        mark_ff <= mark_ff ^ ones_i;
        pos_o <= ones_i & ~mark_ff;
        neg_o <= ones_i & mark_ff;
    end
endmodule : e1fac_line_model

// ---- e1fac_frame_align_control_chk.sv ----
// Concurrent checks on the ports of the E1 framer control block.
`timescale 1ns/1ps
module e1fac_frame_align_control_chk
    import e1fac_pkg::*;
#(
    parameter int CRC_SEARCH_CYC = E1FAC_CRC_SEARCH_CYC
)
(
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input logic [31:0] avs_readdata_o,
    input logic avs_waitrequest_o,
    input wire logic rx_line_pos_i,
    input wire logic rx_line_neg_i,
    input logic rx_data_vld_o,
    input logic rx_signal_loss_o,
    input logic rx_frame_loss_o,
    input wire logic frm_stb_i,
    input wire logic frm_fas_ok_i,
    input logic tx_bit_stb_o,
    input logic tx_line_pos_o,
    input logic tx_line_neg_o
);
    // One clock domain: clock and reset given once.
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    // A request is answered next cycle, for one cycle.
    sequence s_req; (avs_read_i || avs_write_i) && avs_waitrequest_o; endsequence
    sequence s_ans; !avs_waitrequest_o ##1 avs_waitrequest_o; endsequence
    property p_bus; s_req |=> s_ans; endproperty
    property p_rd_hi; !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h000000; endproperty
    property p_lock; $fell(rx_frame_loss_o) |-> $past(frm_stb_i && frm_fas_ok_i); endproperty
    property p_los; $rose(rx_signal_loss_o) |-> !$past(rx_line_pos_i, 6) && !$past(rx_line_neg_i, 6); endproperty
    // Strobes come 24 or 25 cycles apart.
    sequence s_stb_next; ##[24:25] tx_bit_stb_o; endsequence
    property p_stb; tx_bit_stb_o |-> s_stb_next; endproperty
    property p_stb_one; tx_bit_stb_o |=> !tx_bit_stb_o; endproperty
    property p_tx_hold; !tx_bit_stb_o |=> $stable({tx_line_pos_o, tx_line_neg_o}); endproperty
    property p_tx_excl; !(tx_line_pos_o && tx_line_neg_o); endproperty
    property p_vld; rx_data_vld_o |=> !rx_data_vld_o; endproperty
    a_bus: assert property (p_bus) else $error("bus answer not one cycle");
    a_rd_hi: assert property (p_rd_hi) else $error("read data upper bits set");
    a_lock: assert property (p_lock) else $error("lock without alignment word");
    a_los: assert property (p_los) else $error("signal loss while line active");
    a_stb: assert property (p_stb) else $error("transmit strobe spacing");
    a_stb_one: assert property (p_stb_one) else $error("transmit strobe too long");
    a_tx_hold: assert property (p_tx_hold) else $error("line output moved off strobe");
    a_tx_excl: assert property (p_tx_excl) else $error("both line outputs high");
    a_vld: assert property (p_vld) else $error("receive valid too long");
endmodule : e1fac_frame_align_control_chk

bind e1fac_frame_align_control e1fac_frame_align_control_chk #(.CRC_SEARCH_CYC(CRC_SEARCH_CYC)) u_chk (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .rx_line_pos_i(rx_line_pos_i),
    .rx_line_neg_i(rx_line_neg_i), .rx_data_vld_o(rx_data_vld_o), .rx_signal_loss_o(rx_signal_loss_o),
    .rx_frame_loss_o(rx_frame_loss_o), .frm_stb_i(frm_stb_i), .frm_fas_ok_i(frm_fas_ok_i),
    .tx_bit_stb_o(tx_bit_stb_o), .tx_line_pos_o(tx_line_pos_o), .tx_line_neg_o(tx_line_neg_o));

// ---- test_e1fac_frame_align_control.sv ----
// Self-checking bench for the E1 framer control block.
`timescale 1ns/1ps
module test_e1fac_frame_align_control;
    import e1fac_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [7:0] adr = 8'h00;
    logic rd_q = 1'b0;
    logic wr_q = 1'b0;
    logic [31:0] wdat = 32'h00000000;
    logic fstb = 1'b0;
    logic fok = 1'b0;
    logic b2ok = 1'b0;
    logic mstb = 1'b0;
    logic ln_one = 1'b1;
    logic [8:0] rnd = 9'h000;
    logic [31:0] rdat;
    logic wreq, lp, ln, lc, rxd, rxv, los, lof, tstb, tp, tn;
    logic [7:0] r;
    logic [7:0] cfg [4] = '{8'h00, 8'h00, 8'h04, 8'h02};
    logic [3:0] fas_t = 4'b0110;
    logic [3:0] loss_t = 4'b0101;
    int mdl [64] = '{default: 0};
    int n_fail = 0;
    int n_tests = 0;
    int cyc = 0;

    e1fac_frame_align_control #(.CRC_SEARCH_CYC(200)) u_e1fac_frame_align_control (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .avs_address_i(adr), .avs_read_i(rd_q), .avs_write_i(wr_q),
        .avs_writedata_i(wdat), .avs_byteenable_i(4'hF), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
        .rx_line_pos_i(lp), .rx_line_neg_i(ln), .rx_line_clk_i(lc), .rx_data_o(rxd), .rx_data_vld_o(rxv),
        .rx_signal_loss_o(los), .rx_frame_loss_o(lof), .frm_stb_i(fstb), .frm_fas_ok_i(fok), .frm_bit2_ok_i(b2ok),
        .crc_mf_stb_i(mstb), .crc_mf_ok_i(1'b1), .crc_word_stb_i(rnd[4]), .crc_word_err_i(rnd[5]),
        .cas_mf_stb_i(rnd[6]), .cas_mf_ok_i(rnd[7]), .cas_ts16_nonzero_i(rnd[8]), .tx_serial_in_i(rnd[0]),
        .tx_ovh_bit_i(rnd[1]), .tx_ts0_pos_i(rnd[2]), .tx_si_pos_i(rnd[3]), .tx_bit_stb_o(tstb),
        .tx_line_pos_o(tp), .tx_line_neg_o(tn));
    e1fac_line_model u_e1fac_line_model (.ones_i(ln_one), .pos_o(lp), .neg_o(ln), .clk_o(lc));

    // Clock, random inputs and hang guard; a run takes about 20000 cycles.
    always #10 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) rnd <= 9'($urandom);
    always @(posedge clk_sys_i)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            n_fail++;
            final_report();
        end
    end

    task automatic final_report();
        $display("tests=%0d fails=%0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : final_report

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One bus cycle; the model keeps only storable bits.
    task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d);
        @(posedge clk_sys_i);
        adr <= {idx, 2'b00};
        wr_q <= w;
        rd_q <= ~w;
        wdat <= {24'h000000, d};
        do @(posedge clk_sys_i); while (wreq !== 1'b0);
        r = rdat[7:0];
        rd_q <= 1'b0;
        wr_q <= 1'b0;
        if (w && idx inside {6'h1D, 6'h1E, 6'h1F})
            mdl[idx] = d & ((idx == 6'h1D) ? 8'h67 : (idx == 6'h1E) ? 8'h92 : 8'h03);
    endtask : bus

    task automatic rdc(input logic [5:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        chk(r, exp);
    endtask : rdc

    task automatic frame(input logic f, input logic b);
        @(posedge clk_sys_i);
        fstb <= 1'b1;
        fok <= f;
        b2ok <= b;
        @(posedge clk_sys_i);
        fstb <= 1'b0;
        repeat (6) @(posedge clk_sys_i);
    endtask : frame

    task automatic lock();
        frame(1'b1, 1'b1);
        frame(1'b0, 1'b1);
        frame(1'b1, 1'b1);
    endtask : lock

    task automatic line(input logic o, input int nb);
        ln_one <= o;
        repeat (nb * 25) @(posedge clk_sys_i);
    endtask : line

    // Reset values, resync table, CRC4 search, signal loss, unmapped register.
    initial
    begin
        void'($urandom(18));
        repeat (2) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        rdc(6'h12, 8'h00);
        for (int i = 29; i < 32; i++) rdc(i[5:0], mdl[i][7:0]);
        rdc(6'h05, 8'h00);
        for (int k = 0; k < 4; k++)
        begin
            bus(1'b1, 6'h1D, cfg[k] | 8'h01);
            repeat (3) @(posedge clk_sys_i);
            chk({7'h0, lof}, 8'h01);
            rdc(6'h1C, 8'h04);
            bus(1'b1, 6'h1D, cfg[k]);
            lock();
            chk({7'h0, lof}, 8'h00);
            rdc(6'h1C, 8'h00);
            repeat (6) frame(fas_t[k], ~fas_t[k]);
            chk({7'h0, lof}, {7'h0, loss_t[k]});
            rdc(6'h12, (k == 1) ? 8'h00 : 8'h02);
            rdc(6'h12, 8'h00);
        end
        bus(1'b1, 6'h1F, 8'h01);
        bus(1'b1, 6'h1D, 8'h01);
        bus(1'b1, 6'h1D, 8'h00);
        lock();
        repeat (260) @(posedge clk_sys_i);
        rdc(6'h1C, 8'h09);
        repeat (200) @(posedge clk_sys_i);
        rdc(6'h1C, 8'h01);
        repeat (2)
        begin
            @(posedge clk_sys_i);
            mstb <= 1'b1;
            @(posedge clk_sys_i);
            mstb <= 1'b0;
        end
        repeat (2) @(posedge clk_sys_i);
        rdc(6'h1C, 8'h00);
        line(1'b0, 300);
        chk({7'h0, los}, 8'h01);
        line(1'b1, 40);
        chk({7'h0, los}, 8'h00);
        bus(1'b1, 6'h1D, 8'h40);
        line(1'b0, 300);
        chk({7'h0, los}, 8'h00);
        line(1'b1, 40);
        bus(1'b1, 6'h1D, 8'h67);
        bus(1'b1, 6'h1E, 8'h12);
        bus(1'b1, 6'h05, 8'hFF);
        for (int i = 29; i < 31; i++) rdc(i[5:0], mdl[i][7:0]);
        rdc(6'h05, 8'h00);
        final_report();
    end
endmodule : test_e1fac_frame_align_control
